// file: shared/csf_pkg.sv
package csf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned DW     = 16;
    localparam int unsigned BUS_W  = 32;
    localparam int unsigned ADR_W  = 8;
    localparam int unsigned SEL_W  = 4;
    localparam int unsigned EVT_W  = 3;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_SR   = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_EVT  = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;

    ////////////////////////////////////////////////////////////////////////
    // Status word field positions
    localparam int unsigned B_OA   = 15;
    localparam int unsigned B_OB   = 14;
    localparam int unsigned B_SA   = 13;
    localparam int unsigned B_SB   = 12;
    localparam int unsigned B_OAB  = 11;
    localparam int unsigned B_SAB  = 10;
    localparam int unsigned B_LOOP = 9;
    localparam int unsigned B_HC   = 8;
    localparam int unsigned B_IPLH = 7;
    localparam int unsigned B_IPLL = 5;
    localparam int unsigned B_REP  = 4;
    localparam int unsigned B_N    = 3;
    localparam int unsigned B_OV   = 2;
    localparam int unsigned B_Z    = 1;
    localparam int unsigned B_C    = 0;

    // Control word field position
    localparam int unsigned B_NEST = 0;

    // Event bit positions
    localparam int unsigned E_SAT_A = 0;
    localparam int unsigned E_SAT_B = 1;
    localparam int unsigned E_OVF   = 2;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [15:0] SR_RST   = 16'h0000;
    localparam logic        NEST_RST = 1'b0;
    localparam logic [2:0]  EVT_RST  = 3'h0;
    localparam logic [2:0]  MASK_RST = 3'h0;

    // Cycles from request edge to ack
    localparam int unsigned ACK_CYC = 1;

endpackage : csf_pkg

// file: test/test_cpu_status_flag_register.sv
`timescale 1ns/1ps
module test_cpu_status_flag_register;
    import csf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Stimulus, outputs and expected state
    logic             clk           = 1'b0;
    logic             srst          = 1'b1;
    logic             wb_cyc_i      = 1'b0;
    logic             wb_stb_i      = 1'b0;
    logic             wb_we_i       = 1'b0;
    logic [ADR_W-1:0] wb_adr_i      = 8'h00;
    logic [SEL_W-1:0] wb_sel_i      = 4'h0;
    logic [BUS_W-1:0] wb_dat_i      = 32'h0000_0000;
    logic [BUS_W-1:0] wb_dat_o;
    logic             wb_ack_o;
    logic             alu_valid     = 1'b0;
    logic [DW-1:0]    alu_op_a      = 16'h0000;
    logic [DW-1:0]    alu_op_b      = 16'h0000;
    logic             alu_sub       = 1'b0;
    logic             alu_byte      = 1'b0;
    logic             dsp_valid     = 1'b0;
    logic             acc_a_ovf     = 1'b0;
    logic             acc_b_ovf     = 1'b0;
    logic             acc_a_sat     = 1'b0;
    logic             acc_b_sat     = 1'b0;
    logic             loop_active   = 1'b0;
    logic             repeat_active = 1'b0;
    logic [DW-1:0]    status_q;
    logic             nesting_disable_q;
    logic             irq_q;
    logic [15:0]      exp_sr        = 16'h0000;
    logic [2:0]       exp_ev        = 3'h0;
    logic [2:0]       exp_mk        = 3'h0;
    logic             exp_nest      = 1'b0;
    int               n_errors      = 0;
    int               tests_run     = 0;
    logic [3:0]       dsp_tbl [5]   = '{4'h8, 4'h4, 4'h2, 4'h0, 4'h1};
    logic [19:0]      wr_tbl [4]    = '{20'h2_8C00, 20'h2_8000, 20'h2_2400, 20'h2_3000};
    logic [33:0]      alu_tbl [4]   = '{34'h1_00FF_0001, 34'h0_7FFF_0001,
                                        34'h2_0000_0001, 34'h3_0080_0001};

    csf_status_reg dut (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alu_valid(alu_valid),
        .alu_op_a(alu_op_a), .alu_op_b(alu_op_b), .alu_sub(alu_sub), .alu_byte(alu_byte),
        .dsp_valid(dsp_valid), .acc_a_ovf(acc_a_ovf), .acc_b_ovf(acc_b_ovf),
        .acc_a_sat(acc_a_sat), .acc_b_sat(acc_b_sat), .loop_active(loop_active),
        .repeat_active(repeat_active), .status_q(status_q),
        .nesting_disable_q(nesting_disable_q), .irq_q(irq_q));

    // Core clock, 100 MHz
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // Expected flags {hc, n, ov, z, c} of one ALU result
    function automatic logic [4:0] alu_exp(logic [15:0] a, logic [15:0] b, logic sub,
                                           logic byt);
        logic [15:0] bb;
        logic [16:0] r;
        logic [8:0]  h;
        bb = sub ? ~b : b;
        if (byt) begin
            r = {9'h000, a[7:0]} + {9'h000, bb[7:0]} + 17'(sub);
            h = {4'h0, a[3:0]} + {4'h0, bb[3:0]} + 9'(sub);
            return {h[4], r[7], (a[7] == bb[7]) && (r[7] != a[7]), r[7:0] == 8'h00, r[8]};
        end
        r = {1'b0, a} + {1'b0, bb} + 17'(sub);
        h = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + 9'(sub);
        return {h[8], r[15], (a[15] == bb[15]) && (r[15] != a[15]), r[15:0] == 16'h0000,
                r[16]};
    endfunction : alu_exp

    // Expected status word after a software write
    function automatic logic [15:0] sr_wr(logic [15:0] o, logic [15:0] w, logic [3:0] s,
                                          logic ns);
        logic [15:0] n;
        n = o;
        if (s[1]) begin
            n[15:14] = w[15:14];
            n[13:12] = w[10] ? w[13:12] : 2'b00;
            n[11]    = w[11] & o[11] & (|w[15:14]);
            n[10]    = |n[13:12];
            n[8]     = w[8];
        end
        if (s[0]) begin
            if (!ns) n[7:5] = w[7:5];
            n[3:0] = w[3:0];
        end
        return n;
    endfunction : sr_wr

    ////////////////////////////////////////////////////////////////////////
    // Compare and report helpers
    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit

    task automatic end_test(input string what);
        $display("Test %s done, %0d mismatches so far", what, n_errors);
    endtask : end_test

    task automatic complete_run();
        $display("Checks made %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // Let one more edge pass, then compare status_q, nesting_disable_q and irq_q with the model
    task automatic chk_all();
        @(posedge clk);
        @(negedge clk);
        cmp_word("status_q", {16'h0000, exp_sr}, {16'h0000, status_q});
        cmp_bit("nesting_disable_q", exp_nest, nesting_disable_q);
        cmp_bit("irq_q", |(exp_ev & exp_mk), irq_q);
    endtask : chk_all

    ////////////////////////////////////////////////////////////////////////
    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                           input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) cmp_bit("wb_ack_o", 1'b1, wb_ack_o);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb_xfer

    // Register write on the given byte lanes, model follows, then full compare
    task automatic reg_w(input logic [7:0] adr, input logic [15:0] dat, input logic [3:0] sel);
        logic [31:0] rd;
        wb_xfer(1'b1, adr, sel, {16'h0000, dat}, rd);
        case (adr)
            OFF_SR:   exp_sr = sr_wr(exp_sr, dat, sel, exp_nest);
            OFF_CTRL: exp_nest = dat[B_NEST];
            OFF_EVT:  exp_ev = exp_ev & ~dat[2:0];
            OFF_MASK: exp_mk = dat[2:0];
            default:  exp_ev = exp_ev;
        endcase
        chk_all();
    endtask : reg_w

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_xfer(1'b0, adr, 4'hF, 32'h0000_0000, rd);
        cmp_word("wb_dat_o", exp, rd);
    endtask : rd_chk

    // One accumulator report {ovf_a, ovf_b, sat_a, sat_b}
    task automatic dsp_rep(input logic [3:0] f);
        @(posedge clk);
        {dsp_valid, acc_a_ovf, acc_b_ovf, acc_a_sat, acc_b_sat} <= {1'b1, f};
        @(posedge clk);
        dsp_valid <= 1'b0;
        exp_sr[15:14] = f[3:2];
        exp_sr[13:12] = exp_sr[13:12] | f[1:0];
        exp_sr[11]    = |f[3:2];
        exp_sr[10]    = |exp_sr[13:12];
        exp_ev        = exp_ev | {|f[3:2], f[0], f[1]};
        chk_all();
    endtask : dsp_rep

    task automatic alu_op(input logic [15:0] a, input logic [15:0] b, input logic sub,
                          input logic byt);
        logic [4:0] e;
        @(posedge clk);
        {alu_valid, alu_op_a, alu_op_b, alu_sub, alu_byte} <= {1'b1, a, b, sub, byt};
        @(posedge clk);
        alu_valid <= 1'b0;
        e = alu_exp(a, b, sub, byt);
        exp_sr[B_HC] = e[4];
        exp_sr[3:0] = e[3:0];
        chk_all();
    endtask : alu_op

    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake
    initial begin
        #200000;
        cmp_bit("watchdog", 1'b0, 1'b1);
        complete_run();
    end

    // Main sequence
    initial begin
        logic [1:0] k;
        void'($urandom(32'h81B7));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        chk_all();
        for (int i = 0; i < 5; i++) rd_chk(8'(i * 4), 32'h0000_0000);
        end_test("reset");
        foreach (dsp_tbl[i]) dsp_rep(dsp_tbl[i]);
        rd_chk(OFF_EVT, {29'h0, exp_ev});
        end_test("accumulators");
        dsp_rep(4'h8);
        foreach (wr_tbl[i]) reg_w(OFF_SR, wr_tbl[i][15:0], wr_tbl[i][19:16]);
        end_test("status writes");
        reg_w(OFF_CTRL, 16'h0001, 4'h1);
        reg_w(OFF_SR, 16'h00E5, 4'h1);
        reg_w(OFF_CTRL, 16'h0000, 4'h1);
        reg_w(OFF_SR, 16'h00A0, 4'h1);
        end_test("priority lock");
        reg_w(OFF_MASK, 16'h0001, 4'h1);
        reg_w(OFF_EVT, 16'h0001, 4'h1);
        reg_w(OFF_EVT, 16'h0007, 4'h1);
        reg_w(OFF_MASK, 16'h0007, 4'h1);
        dsp_rep(4'h1);
        rd_chk(OFF_MASK, 32'h0000_0007);
        reg_w(OFF_MASK, 16'h0000, 4'h1);
        reg_w(8'h10, 16'hFFFF, 4'hF);
        end_test("events");
        @(posedge clk);
        {loop_active, repeat_active} <= 2'b11;
        exp_sr[B_LOOP] = 1'b1;
        exp_sr[B_REP] = 1'b1;
        reg_w(OFF_SR, 16'hFFFF, 4'h3);
        foreach (alu_tbl[i]) alu_op(alu_tbl[i][31:16], alu_tbl[i][15:0], alu_tbl[i][33], alu_tbl[i][32]);
        end_test("corners");
        for (int i = 0; i < 80; i++) begin
            k = 2'($urandom_range(0, 2));
            if (k == 2'd0) alu_op(16'($urandom), 16'($urandom), 1'($urandom), 1'($urandom));
            else if (k == 2'd1) dsp_rep(4'($urandom));
            else reg_w(OFF_SR, 16'($urandom), 4'($urandom));
            if (i % 8 == 0) rd_chk(OFF_SR, {16'h0000, exp_sr});
        end
        end_test("random");
        complete_run();
    end

endmodule : test_cpu_status_flag_register

// file: verilog/csf_alu_flags.sv
`timescale 1ns/1ps
module csf_alu_flags
    import csf_pkg::*;
(
    input  wire logic [DW-1:0] op_a,    // First operand
    input  wire logic [DW-1:0] op_b,    // Second operand
    input  wire logic          op_sub,  // Subtract when high
    input  wire logic          op_byte, // Byte sized operation
    output logic               fl_n,    // Negative
    output logic               fl_ov,   // Signed overflow
    output logic               fl_z,    // Zero
    output logic               fl_c,    // Carry, high when no borrow
    output logic               fl_hc    // Half carry
);

    // Adds two fields with carry in, carry out in top bit
    function automatic logic [8:0] add_w(input logic [7:0] x, input logic [7:0] y,
                                          input logic ci);
        add_w = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    endfunction : add_w

    logic [DW-1:0] bb;
    logic [8:0]    lo;
    logic [8:0]    hi;
    logic [8:0]    nib;

    // Flag generation for both operand sizes
    always_comb begin
        bb  = op_sub ? ~op_b : op_b;
        lo  = add_w(op_a[7:0], bb[7:0], op_sub);
        hi  = add_w(op_a[15:8], bb[15:8], lo[8]);
        nib = add_w({4'h0, op_a[3:0]}, {4'h0, bb[3:0]}, op_sub);
        if (op_byte) begin
            fl_n  = lo[7];
            fl_z  = (lo[7:0] == 8'h00);
            fl_c  = lo[8];
            fl_ov = (op_a[7] == bb[7]) && (lo[7] != op_a[7]);
            fl_hc = nib[4];
        end else begin
            fl_n  = hi[7];
            fl_z  = ({hi[7:0], lo[7:0]} == 16'h0000);
            fl_c  = hi[8];
            fl_ov = (op_a[15] == bb[15]) && (hi[7] != op_a[15]);
            fl_hc = lo[8];
        end
    end

endmodule : csf_alu_flags

// file: verilog/csf_evt_bank.sv
`timescale 1ns/1ps
module csf_evt_bank
    import csf_pkg::*;
(
    input  wire logic             clk,    // Core clock
    input  wire logic             srst,   // Synchronous reset
    input  wire logic [EVT_W-1:0] evt,    // Event pulses
    input  wire logic             clr_we, // Write one to clear strobe
    input  wire logic             msk_we, // Mask write strobe
    input  wire logic [EVT_W-1:0] wdat,   // Write data
    output logic      [EVT_W-1:0] sts_q,  // Sticky status
    output logic      [EVT_W-1:0] msk_q,  // Mask, one enables
    output logic                  irq_q   // Level interrupt
);

    logic [EVT_W-1:0] sts_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        sts_d = sts_q;
        if (clr_we) begin
            sts_d = sts_d & ~wdat;
        end
        sts_d = sts_d | evt;
    end

    // Sticky status
    always_ff @(posedge clk) begin
        if (srst) begin
            sts_q <= EVT_RST;
        end else begin
            sts_q <= sts_d;
        end
    end

    // Mask
    always_ff @(posedge clk) begin
        if (srst) begin
            msk_q <= MASK_RST;
        end else if (msk_we) begin
            msk_q <= wdat;
        end
    end

    // Interrupt from next status and mask
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_d & (msk_we ? wdat : msk_q));
        end
    end

endmodule : csf_evt_bank

// file: verilog/csf_status_reg.sv
`timescale 1ns/1ps

module csf_status_reg
    import csf_pkg::*;
(
    input  wire logic             clk,           // Core clock, 100 MHz
    input  wire logic             srst,          // Synchronous reset
    input  wire logic             wb_cyc_i,      // Bus cycle
    input  wire logic             wb_stb_i,      // Bus strobe
    input  wire logic             wb_we_i,       // Write enable
    input  wire logic [ADR_W-1:0] wb_adr_i,      // Byte address
    input  wire logic [SEL_W-1:0] wb_sel_i,      // Byte lanes
    input  wire logic [BUS_W-1:0] wb_dat_i,      // Write data
    output logic      [BUS_W-1:0] wb_dat_o,      // Read data
    output logic                  wb_ack_o,      // Acknowledge
    input  wire logic             alu_valid,     // ALU result strobe
    input  wire logic [DW-1:0]    alu_op_a,      // ALU first operand
    input  wire logic [DW-1:0]    alu_op_b,      // ALU second operand
    input  wire logic             alu_sub,       // ALU subtract
    input  wire logic             alu_byte,      // ALU byte size
    input  wire logic             dsp_valid,     // Accumulator update strobe
    input  wire logic             acc_a_ovf,     // Accumulator A overflowed
    input  wire logic             acc_b_ovf,     // Accumulator B overflowed
    input  wire logic             acc_a_sat,     // Accumulator A saturated
    input  wire logic             acc_b_sat,     // Accumulator B saturated
    input  wire logic             loop_active,   // Loop in progress
    input  wire logic             repeat_active, // Repeat in progress
    output logic      [DW-1:0]    status_q,      // Status word
    output logic                  nesting_disable_q, // Nesting disable
    output logic                  irq_q          // Interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic        req;
    logic        acc;
    logic        wr;
    logic [7:0]  adr_w;
    logic        hit_sr;
    logic        hit_ctrl;
    logic        hit_evt;
    logic        hit_mask;
    logic        wr_lo;
    logic        wr_hi;
    logic [15:0] wdat;
    logic        ack_q;
    logic [BUS_W-1:0] dat_q;

    // Request is taken at the edge where ack is high
    assign req      = wb_cyc_i && wb_stb_i;
    assign acc      = req && ack_q;
    assign wr       = acc && wb_we_i;
    assign adr_w    = {wb_adr_i[7:2], 2'b00};
    assign hit_sr   = (adr_w == OFF_SR);
    assign hit_ctrl = (adr_w == OFF_CTRL);
    assign hit_evt  = (adr_w == OFF_EVT);
    assign hit_mask = (adr_w == OFF_MASK);
    assign wdat     = wb_dat_i[15:0];

    // Status writes per byte lane
    assign wr_lo    = wr && hit_sr && wb_sel_i[0];
    assign wr_hi    = wr && hit_sr && wb_sel_i[1];

    ////////////////////////////////////////////////////////////////////////
    // Flag arithmetic

    logic fl_n;
    logic fl_ov;
    logic fl_z;
    logic fl_c;
    logic fl_hc;

    csf_alu_flags u_alu (
        .op_a    (alu_op_a),
        .op_b    (alu_op_b),
        .op_sub  (alu_sub),
        .op_byte (alu_byte),
        .fl_n    (fl_n),
        .fl_ov   (fl_ov),
        .fl_z    (fl_z),
        .fl_c    (fl_c),
        .fl_hc   (fl_hc)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status word next value

    logic [DW-1:0] sr_d;
    logic          oab_set;
    logic          oab_clr;
    logic          sab_clr;

    assign oab_set = dsp_valid && (acc_a_ovf || acc_b_ovf);
    assign oab_clr = wr_hi && !wdat[B_OAB];
    assign sab_clr = wr_hi && !wdat[B_SAB];

    // Software first, hardware updates override it
    always_comb begin
        sr_d = status_q;
        // Low byte from software
        if (wr_lo) begin
            if (!nesting_disable_q) begin
                sr_d[B_IPLH:B_IPLL] = wdat[B_IPLH:B_IPLL];
            end
            sr_d[B_N:B_C] = wdat[B_N:B_C];
        end
        // High byte from software
        if (wr_hi) begin
            sr_d[B_OA] = wdat[B_OA];
            sr_d[B_OB] = wdat[B_OB];
            sr_d[B_SA] = wdat[B_SA];
            sr_d[B_SB] = wdat[B_SB];
            sr_d[B_HC] = wdat[B_HC];
        end
        // Clearing the combined flag clears both
        if (sab_clr) begin
            sr_d[B_SA] = 1'b0;
            sr_d[B_SB] = 1'b0;
        end
        // Accumulator updates, sticky saturation
        if (dsp_valid) begin
            sr_d[B_OA] = acc_a_ovf;
            sr_d[B_OB] = acc_b_ovf;
            sr_d[B_SA] = sr_d[B_SA] | acc_a_sat;
            sr_d[B_SB] = sr_d[B_SB] | acc_b_sat;
        end
        // ALU result flags
        if (alu_valid) begin
            sr_d[B_N]  = fl_n;
            sr_d[B_OV] = fl_ov;
            sr_d[B_Z]  = fl_z;
            sr_d[B_C]  = fl_c;
            sr_d[B_HC] = fl_hc;
        end
        // Read only mirrors
        sr_d[B_LOOP] = loop_active;
        sr_d[B_REP]  = repeat_active;
        // Combined flags: overflow set by hardware, cleared by software or when OA and OB are both low; saturation is SA or SB
        sr_d[B_OAB] = (oab_set || (status_q[B_OAB] && !oab_clr))
                      && (sr_d[B_OA] || sr_d[B_OB]);
        sr_d[B_SAB] = sr_d[B_SA] || sr_d[B_SB];
    end

    // Status word register
    always_ff @(posedge clk) begin
        if (srst) begin
            status_q <= SR_RST;
        end else begin
            status_q <= sr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register

    // Nesting disable, locks the priority level
    always_ff @(posedge clk) begin
        if (srst) begin
            nesting_disable_q <= NEST_RST;
        end else if (wr && hit_ctrl && wb_sel_i[0]) begin
            nesting_disable_q <= wdat[B_NEST];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events and interrupt

    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] evt_sts;
    logic [EVT_W-1:0] evt_msk;

    // Saturation and overflow events
    always_comb begin
        evt          = '0;
        evt[E_SAT_A] = dsp_valid && acc_a_sat;
        evt[E_SAT_B] = dsp_valid && acc_b_sat;
        evt[E_OVF]   = oab_set;
    end

    csf_evt_bank u_evt (
        .clk    (clk),
        .srst   (srst),
        .evt    (evt),
        .clr_we (wr && hit_evt && wb_sel_i[0]),
        .msk_we (wr && hit_mask && wb_sel_i[0]),
        .wdat   (wdat[EVT_W-1:0]),
        .sts_q  (evt_sts),
        .msk_q  (evt_msk),
        .irq_q  (irq_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus answer

    // Ack one cycle after the request, dropped after one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // Read data captured with ack, unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            dat_q <= '0;
        end else if (req && !ack_q) begin
            dat_q <= '0;
            case (1'b1)
                hit_sr:   dat_q[DW-1:0]    <= status_q;
                hit_ctrl: dat_q[B_NEST]    <= nesting_disable_q;
                hit_evt:  dat_q[EVT_W-1:0] <= evt_sts;
                hit_mask: dat_q[EVT_W-1:0] <= evt_msk;
                default:  dat_q            <= '0;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Combined overflow zero when neither overflowed
    chk_oab_zero_none: assert property (
        !status_q[B_OA] && !status_q[B_OB] |-> !status_q[B_OAB]
    ) else $error("combined overflow set without overflow");

    // Combined overflow follows an overflow report
    chk_oab_set_ovf: assert property (
        oab_set |=> status_q[B_OAB] && (status_q[B_OA] || status_q[B_OB])
    ) else $error("combined overflow not set");

    // Saturation recorded on report
    chk_sat_set_evt: assert property (
        dsp_valid && acc_a_sat |=> status_q[B_SA] && status_q[B_SAB]
    ) else $error("saturation A not recorded");

    // Saturation stays until software writes
    chk_sat_sticky_hold: assert property (
        status_q[B_SB] && !wr_hi [*2] |-> status_q[B_SB]
    ) else $error("saturation B lost");

    // Written saturation value is taken
    chk_sat_write_val: assert property (
        wr_hi && wdat[B_SAB] && !dsp_valid
        |=> status_q[B_SA] == $past(wb_dat_i[B_SA])
    ) else $error("saturation write not taken");

    // Clearing the combined flag clears both
    chk_sab_clear_both: assert property (
        sab_clr && !dsp_valid |=> !status_q[B_SA] && !status_q[B_SB]
    ) else $error("saturation flags not cleared");

    // Priority level locked while nesting disabled
    chk_ipl_locked: assert property (
        nesting_disable_q |=> $stable(status_q[B_IPLH:B_IPLL])
    ) else $error("priority level changed while locked");

    // Priority level written when unlocked
    chk_ipl_write: assert property (
        wr_lo && !nesting_disable_q
        |=> status_q[B_IPLH:B_IPLL] == $past(wdat[B_IPLH:B_IPLL])
    ) else $error("priority level write lost");

    // Software cannot set combined overflow
    chk_oab_no_set: assert property (
        !status_q[B_OAB] && !oab_set |=> !status_q[B_OAB]
    ) else $error("combined overflow set by software");

    // Half carry from the ALU
    chk_half_carry: assert property (
        alu_valid && alu_byte && !alu_sub && alu_op_a[3:0] == 4'hF
        && alu_op_b[3:0] == 4'h1 |=> status_q[B_HC]
    ) else $error("half carry missed");

    // Equal operands subtract to zero with carry
    chk_zero_flag: assert property (
        alu_valid && alu_sub && alu_op_a == alu_op_b
        |=> status_q[B_Z] && status_q[B_C] && !status_q[B_N]
    ) else $error("zero flag wrong");

    // Ack is a one cycle pulse
    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o
    ) else $error("ack held too long");

    // Interrupt follows unmasked status
    chk_irq_level: assert property (
        irq_q == |(evt_sts & evt_msk)
    ) else $error("interrupt level wrong");

    cov_sat_clear: cover property (
        status_q[B_SAB] ##1 sab_clr ##1 !status_q[B_SAB]
    );

    cov_ipl_locked_write: cover property (
        nesting_disable_q && wr_lo
    );

    cov_irq_raise: cover property (
        !irq_q ##1 irq_q
    );

    cov_oab_set_clr: cover property (
        oab_set ##[1:20] oab_clr
    );

endmodule : csf_status_reg
